// [rtl/sarc_seq.sv]
// Conversion sequencer and serial readout of the 16-bit converter
`default_nettype none
`include "sarc_map.svh"
module sarc_seq #(
   parameter int RES   = `SARC_RES_BITS,
   parameter int TWID  = 8
) (
   input  wire  logic                 clk,               // 250 MHz core clock
   input  wire  logic                 resetn,            // Async reset, low
   input  wire  logic                 ce,                // Clock enable
   input  wire  logic                 select_shutdown_n, // Pin, low selects
   input  wire  logic                 conv_clock,        // Pin, host clock
   input  wire  logic                 comp_in,           // Comparator result
   input  wire  logic                 trim_wr,           // Factory trim write
   input  wire  logic [3:0]           trim_waddr,        // Factory address
   input  wire  logic [TWID-1:0]      trim_wdata,        // Factory data
   output var   sarc_pkg::sarc_afe_s  afe,               // Front end controls
   output var   sarc_pkg::sarc_pin_s  pin,               // serial_out pin
   output var   logic [RES-1:0]       dac_code,          // Trial code
   output var   logic [TWID-1:0]      trim_q,            // Applied trim
   output var   logic                 conv_done          // Result ready pulse
);
   localparam logic [4:0] SMPL_EDGES = 5'(`SARC_SMPL_EDGES);
   localparam logic [4:0] LAST_BIT   = 5'(RES);

   typedef struct packed {
      logic [2:0]            cs_sync;
      logic [2:0]            ck_sync;
      logic                  cs_q;
      logic                  ck_q;
      logic                  armed;
      sarc_pkg::sarc_phase_e phase;
      logic [4:0]            fall_cnt;
      logic [4:0]            bit_idx;
      logic [4:0]            out_idx;
      logic                  out_on;
      logic [3:0]            trim_idx;
      logic                  trim_pend;
      logic                  trim_rvalid;
      logic [RES-1:0]        sar;
      logic [RES-1:0]        prev_word;
      logic [RES-1:0]        shift_word;
      sarc_pkg::sarc_afe_s   afe;
      sarc_pkg::sarc_pin_s   pin;
      logic [TWID-1:0]       trim;
      logic                  done;
   } sarc_state_s;

   sarc_state_s st_reg;
   sarc_state_s st_next;
   sarc_pkg::sarc_trim_rd_s trd;
   logic [TWID-1:0] trim_rdata;
   logic cs_fall;
   logic cs_rise;
   logic ck_fall;
   logic ck_rise;
   logic sel;

   // Pin edges once second and third stage agree
   always_comb begin
      cs_fall = st_reg.cs_sync[1] == st_reg.cs_sync[2]
                && !st_reg.cs_sync[2] && st_reg.cs_q;
      cs_rise = st_reg.cs_sync[1] == st_reg.cs_sync[2]
                && st_reg.cs_sync[2] && !st_reg.cs_q;
      sel     = !st_reg.cs_q;
      ck_fall = sel && st_reg.ck_sync[1] == st_reg.ck_sync[2]
                && !st_reg.ck_sync[2] && st_reg.ck_q;
      ck_rise = sel && st_reg.ck_sync[1] == st_reg.ck_sync[2]
                && st_reg.ck_sync[2] && !st_reg.ck_q;
      trd.rd   = st_reg.trim_pend;
      trd.addr = st_reg.trim_idx;
   end

   // Next-state logic for the whole sequencer
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.cs_sync = {st_reg.cs_sync[1:0], select_shutdown_n};
      st_next.ck_sync = {st_reg.ck_sync[1:0], conv_clock};
      if (st_reg.cs_sync[1] == st_reg.cs_sync[2]) begin
         st_next.cs_q = st_reg.cs_sync[2];
      end
      if (st_reg.ck_sync[1] == st_reg.ck_sync[2]) begin
         st_next.ck_q = st_reg.ck_sync[2];
      end
      if (cs_rise) begin
         st_next.armed = 1'b1;
      end
      // Trim reload, one read a core cycle, data a cycle later
      st_next.trim_rvalid = st_reg.trim_pend;
      if (st_reg.trim_rvalid) begin
         st_next.trim = trim_rdata;
      end
      if (st_reg.trim_pend) begin
         if (st_reg.trim_idx == 4'hf) begin
            st_next.trim_pend = 1'b0;
         end
         st_next.trim_idx = st_reg.trim_idx + 4'h1;
      end
      if (ck_fall) begin
         st_next.fall_cnt = (st_reg.fall_cnt == 5'h1f) ? st_reg.fall_cnt
                            : st_reg.fall_cnt + 5'h01;
      end
      // Serial output shifting on falling edges
      if (ck_fall && st_reg.fall_cnt + 5'h01 == SMPL_EDGES) begin
         st_next.pin.dout_oe_n = 1'b0;
         st_next.pin.dout      = 1'b0;
         st_next.out_on        = 1'b1;
         st_next.out_idx       = 5'h00;
         st_next.shift_word    = st_reg.prev_word;
      end else if (ck_fall && st_reg.out_on) begin
         if (st_reg.out_idx == LAST_BIT) begin
            st_next.pin.dout   = 1'b0;
            st_next.out_idx    = 5'h00;
            st_next.shift_word = st_reg.prev_word;
         end else begin
            st_next.pin.dout = st_reg.shift_word[RES-1];
            st_next.shift_word = {st_reg.shift_word[RES-2:0], 1'b0};
            st_next.out_idx    = st_reg.out_idx + 5'h01;
         end
      end
      // Phase sequencing
      case (st_reg.phase)
         sarc_pkg::ST_OFF: begin
            st_next.afe = '0;
            st_next.afe.digital_on = st_reg.afe.digital_on;
            if (cs_fall && st_reg.armed) begin
               st_next.phase          = sarc_pkg::ST_SAMPLE;
               st_next.armed          = 1'b0;
               st_next.fall_cnt       = 5'h00;
               st_next.out_on         = 1'b0;
               st_next.afe.digital_on = 1'b1;
               st_next.afe.analog_on  = 1'b1;
               st_next.afe.sample_en  = 1'b1;
            end
         end
         sarc_pkg::ST_SAMPLE: begin
            // Sampling ends mid-period after the fifth falling edge
            if (ck_fall && st_reg.fall_cnt + 5'h01 == SMPL_EDGES) begin
               st_next.afe.sample_en = 1'b0;
               st_next.afe.hold      = 1'b1;
               st_next.afe.isolate   = 1'b1;
               st_next.trim_pend     = 1'b1;
               st_next.trim_idx      = 4'h0;
               st_next.phase         = sarc_pkg::ST_TRIM;
            end
         end
         sarc_pkg::ST_TRIM: begin
            if (!st_reg.trim_pend && !st_reg.trim_rvalid) begin
               st_next.phase   = sarc_pkg::ST_CONVERT;
               st_next.bit_idx = 5'h00;
               st_next.sar     = {1'b1, {(RES-1){1'b0}}};
            end
         end
         sarc_pkg::ST_CONVERT: begin
            st_next.afe.isolate = 1'b1;
            if (ck_rise) begin
               st_next.sar[RES-1-st_reg.bit_idx] = comp_in;
               if (st_reg.bit_idx != LAST_BIT - 5'h01) begin
                  st_next.sar[RES-2-st_reg.bit_idx] = 1'b1;
                  st_next.bit_idx = st_reg.bit_idx + 5'h01;
               end else begin
                  st_next.phase = sarc_pkg::ST_DONE;
               end
            end
         end
         sarc_pkg::ST_DONE: begin
            st_next.prev_word     = st_reg.sar;
            st_next.done          = 1'b1;
            st_next.afe.analog_on = 1'b0;
            st_next.afe.isolate   = 1'b0;
            st_next.afe.hold      = 1'b0;
            st_next.phase         = sarc_pkg::ST_OFF;
            st_next.afe.digital_on = 1'b1;
         end
         default: st_next.phase = sarc_pkg::ST_OFF;
      endcase
      // Deselect shuts everything and floats the pin
      if (st_reg.cs_q && !cs_fall) begin
         st_next.pin.dout_oe_n  = 1'b1;
         st_next.out_on         = 1'b0;
         st_next.afe            = '0;
         st_next.phase          = sarc_pkg::ST_OFF;
         st_next.trim_pend      = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '{cs_sync: 3'h7, ck_sync: 3'h0, cs_q: 1'b1, ck_q: 1'b0,
                     armed: 1'b1, phase: sarc_pkg::ST_OFF,
                     pin: '{dout: 1'b0, dout_oe_n: 1'b1},
                     prev_word: `SARC_RESULT_RST, default: '0};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // Outputs from the state register
   always_comb begin
      afe       = st_reg.afe;
      pin       = st_reg.pin;
      dac_code  = st_reg.sar;
      trim_q    = st_reg.trim;
      conv_done = st_reg.done;
   end

   sarc_trim_mem #(.WIDTH(TWID), .DEPTH(`SARC_TRIM_WORDS)) u_trim (
      .clk   (clk),
      .ce    (ce),
      .rd    (trd.rd),
      .addr  (st_reg.trim_pend ? trd.addr : trim_waddr),
      .wr    (trim_wr && !st_reg.trim_pend),
      .wdata (trim_wdata),
      .rdata (trim_rdata)
   );

   property p_float_when_off;
      @(posedge clk) disable iff (!resetn)
      ce && st_reg.cs_q |=> pin.dout_oe_n;
   endproperty
   a_float_when_off: assert property (p_float_when_off)
      else $error("serial_out driven while deselected");

   property p_isolated_in_convert;
      @(posedge clk) disable iff (!resetn)
      st_reg.phase == sarc_pkg::ST_CONVERT |-> afe.isolate && !afe.sample_en;
   endproperty
   a_isolated_in_convert: assert property (p_isolated_in_convert)
      else $error("inputs connected during conversion");

   property p_trim_before_convert;
      @(posedge clk) disable iff (!resetn)
      $rose(st_reg.phase == sarc_pkg::ST_CONVERT)
         |-> $past(st_reg.phase == sarc_pkg::ST_TRIM);
   endproperty
   a_trim_before_convert: assert property (p_trim_before_convert)
      else $error("approximation began without trim reload");

   property p_start_bit_low;
      @(posedge clk) disable iff (!resetn)
      ce && ck_fall && st_reg.fall_cnt == 5'h04 && !st_reg.cs_q
         |=> !pin.dout_oe_n && !pin.dout;
   endproperty
   a_start_bit_low: assert property (p_start_bit_low)
      else $error("no low start bit after fifth falling edge");

   property p_pin_changes_on_fall;
      @(posedge clk) disable iff (!resetn)
      ce && !ck_fall |=> $stable(pin.dout) || pin.dout_oe_n;
   endproperty
   a_pin_changes_on_fall: assert property (p_pin_changes_on_fall)
      else $error("serial_out changed away from a falling edge");

   property p_sample_at_start;
      @(posedge clk) disable iff (!resetn)
      ce && st_reg.phase == sarc_pkg::ST_OFF && cs_fall && st_reg.armed
         |=> afe.sample_en;
   endproperty
   a_sample_at_start: assert property (p_sample_at_start)
      else $error("input not sampled at cycle start");

   property p_analog_off_after;
      @(posedge clk) disable iff (!resetn)
      conv_done |-> !afe.analog_on;
   endproperty
   a_analog_off_after: assert property (p_analog_off_after)
      else $error("analog still powered after conversion");

   property p_prev_word_loaded;
      @(posedge clk) disable iff (!resetn)
      conv_done |-> st_reg.prev_word == $past(st_reg.sar);
   endproperty
   a_prev_word_loaded: assert property (p_prev_word_loaded)
      else $error("result not kept for next readout");
endmodule : sarc_seq
`default_nettype wire

// [rtl/sarc_map.svh]
// Resolution, reset value, trim depth and timing counts of the conversion sequencer
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH
`define SARC_RES_BITS      16
`define SARC_RESULT_RST    16'h0000
`define SARC_SMPL_EDGES    5
`define SARC_CONV_EDGES    18
`define SARC_TRIM_WORDS    16
`define SARC_CYC_MIN       24
`endif

// [rtl/sarc_pkg.sv]
// Types shared by the conversion sequencer
`default_nettype none
`include "sarc_map.svh"
package sarc_pkg;
   typedef enum logic [2:0] {
      ST_OFF, ST_SAMPLE, ST_TRIM, ST_CONVERT, ST_DONE
   } sarc_phase_e;
   typedef logic [`SARC_RES_BITS-1:0] sarc_word_t;
   // Analog front end controls
   typedef struct packed {
      logic sample_en;    // Input switches closed
      logic hold;         // Array holds captured difference
      logic isolate;      // Inputs disconnected
      logic analog_on;    // Comparator powered
      logic digital_on;   // Digital section powered
   } sarc_afe_s;
   // Serial output pin pair
   typedef struct packed {
      logic dout;         // Data level
      logic dout_oe_n;    // Low while driving
   } sarc_pin_s;
   // Trim memory read request
   typedef struct packed {
      logic       rd;
      logic [3:0] addr;
   } sarc_trim_rd_s;
endpackage : sarc_pkg
`default_nettype wire

// [rtl/sarc_trim_mem.sv]
// Non-volatile trim store model with registered read data
`default_nettype none
`include "sarc_map.svh"
module sarc_trim_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `SARC_TRIM_WORDS
) (
   input  wire  logic                     clk,      // Core clock
   input  wire  logic                     ce,       // Clock enable
   input  wire  logic                     rd,       // Read strobe
   input  wire  logic [$clog2(DEPTH)-1:0] addr,     // Word address
   input  wire  logic                     wr,       // Factory write strobe
   input  wire  logic [WIDTH-1:0]         wdata,    // Factory write data
   output var   logic [WIDTH-1:0]         rdata     // Registered read data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Write on factory strobe, read registered
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr) begin
            mem[addr] <= wdata;
         end
         if (rd) begin
            rdata <= mem[addr];
         end
      end
   end
endmodule : sarc_trim_mem
`default_nettype wire

// [tb/sarc_host_model.sv]
// Host controller model: select line, conversion clock and serial capture
`default_nettype none
module sarc_host_model (
   input  wire logic                clk,               // Core clock
   input  wire sarc_pkg::sarc_pin_s pin,               // serial_out pin
   output var  logic                select_shutdown_n, // Select, low active
   output var  logic                conv_clock         // Conversion clock
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 13; // 52 ns halves, 9.6 MHz

   // Idle host: deselected, clock parked low
   initial begin
      select_shutdown_n = 1'b1;
      conv_clock        = 1'b0;
   end

   // One frame of n clock periods, capture on each rising edge
   task automatic frame(input int n, input bit stray,
                        output logic [15:0] w0, output logic [15:0] w1,
                        output logic [1:0] sb, output logic bad);
      logic b;
      w0  = '0;
      w1  = '0;
      sb  = '1;
      bad = 1'b0;
      // Stray edges while deselected must not count
      if (stray) begin
         repeat (6) begin
            repeat (HALF) @(posedge clk);
            if (pin.dout_oe_n !== 1'b1) bad = 1'b1;
            conv_clock <= ~conv_clock;
         end
      end
      repeat (HALF) @(posedge clk);
      select_shutdown_n <= 1'b0; // fall after high starts a cycle
      repeat (HALF) @(posedge clk);
      // Keep clocking past the conversion end
      for (int k = 1; k <= n; k++) begin
         conv_clock <= 1'b1;
         repeat (2) @(posedge clk);
         b = pin.dout; // bit launched by the previous fall
         if (k >= 6 && pin.dout_oe_n !== 1'b0) bad = 1'b1;
         if (k == 6) sb[1] = b;
         else if (k >= 7 && k <= 22) w0 = {w0[14:0], b};
         else if (k == 23) sb[0] = b;
         else if (k >= 24 && k <= 39) w1 = {w1[14:0], b};
         repeat (HALF - 2) @(posedge clk);
         if (k >= 6 && pin.dout !== b) bad = 1'b1; // stable while high
         conv_clock <= 1'b0;
         repeat (HALF) @(posedge clk);
      end
      select_shutdown_n <= 1'b1;
      repeat (2 * HALF) @(posedge clk);
   endtask
endmodule // sarc_host_model
`default_nettype wire

// [tb/sar_adc_conversion_readout_tb.sv]
// Self-checking bench of the conversion sequencer and serial readout
`default_nettype none
`include "sarc_map.svh"
module sar_adc_conversion_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] target;
      logic        stray;
      logic [15:0] exp_w0;
   } sarc_row_s;

   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic                comp_in = 1'b0;
   logic                trim_wr = 1'b0;
   logic [3:0]          trim_waddr = 4'h0;
   logic [7:0]          trim_wdata = 8'h00;
   logic [15:0]         target = 16'h0000;
   logic                select_shutdown_n;
   logic                conv_clock;
   sarc_pkg::sarc_afe_s afe;
   sarc_pkg::sarc_pin_s pin;
   logic [15:0]         dac_code;
   logic [7:0]          trim_q;
   logic                conv_done;
   int                  done_cnt = 0;
   int                  miscompares = 0;
   int                  samples_checked = 0;
   sarc_row_s           rows [5] = '{
      '{16'h8001, 1'b0, 16'h0000}, '{16'hffff, 1'b1, 16'h8001},
      '{16'h0000, 1'b0, 16'hffff}, '{16'h5a3c, 1'b1, 16'h0000},
      '{16'h0001, 1'b0, 16'h5a3c}};

   always #2 clk = ~clk;

   sarc_seq dut (.clk(clk), .resetn(resetn), .ce(1'b1),
      .select_shutdown_n(select_shutdown_n), .conv_clock(conv_clock),
      .comp_in(comp_in), .trim_wr(trim_wr), .trim_waddr(trim_waddr),
      .trim_wdata(trim_wdata), .afe(afe), .pin(pin), .dac_code(dac_code),
      .trim_q(trim_q), .conv_done(conv_done));

   sarc_host_model host (.clk(clk), .pin(pin),
      .select_shutdown_n(select_shutdown_n), .conv_clock(conv_clock));

   // Ideal comparator: keep the trial bit while it does not overshoot
   always @(posedge clk) comp_in <= (dac_code <= target);

   // Count completed conversions
   always @(posedge clk) if (conv_done === 1'b1) done_cnt <= done_cnt + 1;

   task automatic conclude();
      $display("miscompares %0d samples_checked %0d",
               miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One frame through the host, then the readout and state checks
   task automatic run(input int n, input bit stray,
                      input logic [15:0] tgt, input logic [15:0] exp0);
      logic [15:0] w0;
      logic [15:0] w1;
      logic [1:0]  sb;
      logic        bad;
      int          d0;
      target <= tgt;
      d0 = done_cnt;
      host.frame(n, stray, w0, w1, sb, bad);
      chk(32'(w0), 32'(exp0));
      if (n >= 39) chk(32'(w1), 32'(tgt));
      chk(32'({sb, bad}), 32'h0);
      chk(32'(done_cnt - d0), 32'h1);
      chk(32'(trim_q), 32'h3f);
      chk(32'({afe.analog_on, afe.digital_on, pin.dout_oe_n}),
          32'h1);
   endtask

   // Watchdog on the whole run
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      conclude();
   end

   // Main sequence: reset, trim load, table, then awkward cases
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         trim_wr    <= 1'b1;
         trim_waddr <= 4'(i);
         trim_wdata <= 8'h30 + 8'(i);
         @(posedge clk);
      end
      trim_wr <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) run(39, rows[i].stray, rows[i].target, rows[i].exp_w0);
      // Minimum-length frame still completes its conversion
      run(24, 1'b0, 16'ha5c3, 16'h0001);
      run(39, 1'b0, 16'h7ffe, 16'ha5c3);
      // Mid-run reset, then one cycle restores the trim
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'({pin.dout_oe_n, conv_done, dac_code}), 32'h20000);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      run(39, 1'b1, 16'h1234, `SARC_RESULT_RST);
      conclude();
   end
endmodule // sar_adc_conversion_readout_tb
`default_nettype wire
